// *** logic/cosw_ctrl.sv ***
// clock-out select, stop and wait mode controller
// What this block does
// - in single-chip mode, route div8, div32 or sub-clock to the clock-out pin
// - select 00 port pin, 01 sub-clock, 10 div8, 11 div32
// - wait with peripheral-stop bit set halts div8/div32 on clock-out
// - writing 1 to the all-clock-stop bit enters stop mode
// - stop gates cpu, peripheral, sub-clock, converter and watchdog clocks
// - stop keeps external-event timers and external-clock serial alive
// - stop ends on reset or accepted interrupt, which then runs its routine
// - entering stop from high/medium speed or reset sets divide bit 0
// - expansion-mode stop holds bus pins, drives strobes and clock high
// - single-chip stop: sub-clock selected drives pin high, else hold
// - wait stops cpu clock and watchdog, oscillators keep running
// - wait with peripheral-stop bit gates peripheral clocks except div32 sub
// - wait ends on reset or interrupt, prior cpu clock source restored
// - expansion-mode wait holds bus pins, drives strobes and clock high
// - single-chip wait: sub-clock toggles, divided clocks per stop bit
// - after reset the cpu clock is main clock divided by 8
// - divide bit 0 low selects 1/2/4/16 by two bits, high fixes 8
module cosw_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration
  input wire cosw_pkg::cosw_cfg_s cfg,
  input wire logic single_chip_mode,
  input wire logic divide_select_bit0_wr,
  input wire logic divide_select_bit0_wdata,
  // requests from the cpu core
  input wire logic all_clock_stop_bit_wr,
  input wire logic wait_instr,
  // wake events and sub-clock from pins
  input wire logic wake_irq_pin,
  input wire logic wake_nmi_pin,
  input wire logic sub_clock,
  // bus pin values from the cpu in normal operation
  input wire logic [7:0] bus_pins_live,
  input wire logic [3:0] strobes_live,
  input wire logic ale_live,
  // status
  output logic divide_select_bit0,
  output cosw_pkg::cosw_state_e mode,
  output logic wake_ack,
  output logic run_isr,
  // clock gates
  output cosw_pkg::cosw_gate_s gates,
  output logic cpu_tick,
  // pins
  output logic clock_out_pin,
  output logic clock_out_pin_oe_n,
  output logic [7:0] bus_pins,
  output logic [3:0] strobes,
  output logic hold_acknowledge,
  output logic cpu_clock_pin,
  output logic ale
);
  import cosw_pkg::*;

  cosw_state_e state_q;
  cosw_state_e state_d;
  logic divsel0_q;
  logic [1:0] restart_q;
  logic irq_s;
  logic nmi_s;
  logic sub_s;
  logic wake;
  logic low_speed;
  logic osc_run;
  logic [4:0] cpu_ratio;
  logic div8_level;
  logic div32_level;
  logic clock_out_pin_q;
  logic [7:0] bus_hold_q;
  logic [3:0] strobe_q;
  logic ale_q;
  logic woke_irq_q;

  cosw_sync u_sync_irq (
    .clk(clk),
    .resetn(resetn),
    .din(wake_irq_pin),
    .dout(irq_s)
  );

  cosw_sync u_sync_nmi (
    .clk(clk),
    .resetn(resetn),
    .din(wake_nmi_pin),
    .dout(nmi_s)
  );

  cosw_sync u_sync_sub (
    .clk(clk),
    .resetn(resetn),
    .din(sub_clock),
    .dout(sub_s)
  );

  // wake path runs off the free clock, not the gated cpu tick
  assign wake = irq_s || nmi_s;
  assign low_speed = cfg.system_clock_sub;
  assign osc_run = (state_q != COSW_STOP);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      COSW_RUN: begin
        if (all_clock_stop_bit_wr) begin
          state_d = COSW_STOP;
        end else if (wait_instr) begin
          state_d = COSW_WAIT;
        end
      end
      COSW_WAIT: begin
        if (wake) begin
          state_d = COSW_RUN;
        end
      end
      COSW_STOP: begin
        if (wake) begin
          state_d = COSW_RESTART;
        end
      end
      COSW_RESTART: begin
        if (restart_q == RESTART_ZERO) begin
          state_d = COSW_RUN;
        end
      end
      default: begin
        state_d = COSW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= COSW_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      restart_q <= RESTART_ZERO;
    end else if (state_q == COSW_STOP) begin
      restart_q <= RESTART_CYCLES;
    end else if (restart_q != RESTART_ZERO) begin
      restart_q <= restart_q - 2'h1;
    end
  end

  // divide bit 0: set on reset and on stop entry from main clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divsel0_q <= DIVSEL0_RESET;
    end else if (state_q == COSW_RUN && all_clock_stop_bit_wr) begin
      if (!low_speed) begin
        divsel0_q <= 1'b1;
      end
    end else if (divide_select_bit0_wr) begin
      divsel0_q <= divide_select_bit0_wdata;
    end
  end
  assign divide_select_bit0 = divsel0_q;

  // cpu clock ratio
  always_comb begin
    if (divsel0_q) begin
      cpu_ratio = RATIO_8;
    end else begin
      unique case ({cfg.divide_select1_high, cfg.divide_select1_low})
        DIVSEL_NONE: cpu_ratio = RATIO_1;
        DIVSEL_2: cpu_ratio = RATIO_2;
        DIVSEL_4: cpu_ratio = RATIO_4;
        DIVSEL_16: cpu_ratio = RATIO_16;
      endcase
    end
  end

  logic main_tick;
  cosw_divider u_div (
    .clk(clk),
    .resetn(resetn),
    .run(osc_run),
    .cpu_ratio(cpu_ratio),
    .cpu_tick(main_tick),
    .div8_level(div8_level),
    .div32_level(div32_level)
  );

  // cpu clock runs only in run; ticks on every clk cycle in low-speed modes
  assign cpu_tick = (state_q == COSW_RUN) &&
                    (low_speed ? 1'b1 : main_tick);

  always_comb begin
    gates = '0;
    unique case (state_q)
      COSW_RUN: begin
        gates = '1;
      end
      COSW_WAIT: begin
        gates.oscillator_en = 1'b1;
        gates.sub_clock_en = 1'b1;
        gates.sub_clock_div32_en = 1'b1;
        gates.periph_clock_en = !cfg.wait_periph_clock_stop_bit;
        gates.converter_clock_en = !cfg.wait_periph_clock_stop_bit;
        gates.ext_event_en = 1'b1;
      end
      COSW_STOP: begin
        gates.ext_event_en = 1'b1;
      end
      COSW_RESTART: begin
        gates.oscillator_en = 1'b1;
        gates.ext_event_en = 1'b1;
      end
      default: begin
        gates = '0;
      end
    endcase
  end

  // wake handshake; interrupt wake hands the routine to the cpu
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      woke_irq_q <= 1'b0;
    end else begin
      woke_irq_q <= (state_q != COSW_RUN) && (state_d == COSW_RUN);
    end
  end
  assign wake_ack = woke_irq_q;
  assign run_isr = woke_irq_q;

  // clock-out pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_out_pin_q <= 1'b0;
    end else begin
      unique case (cfg.clock_out_sel)
        COSEL_PORT: clock_out_pin_q <= 1'b0;
        COSEL_SUB: begin
          if (state_q == COSW_STOP) begin
            clock_out_pin_q <= 1'b1;
          end else begin
            clock_out_pin_q <= sub_s;
          end
        end
        COSEL_DIV8: begin
          if (state_q == COSW_STOP ||
              (state_q == COSW_WAIT && cfg.wait_periph_clock_stop_bit)) begin
            clock_out_pin_q <= clock_out_pin_q;
          end else begin
            clock_out_pin_q <= div8_level;
          end
        end
        COSEL_DIV32: begin
          if (state_q == COSW_STOP ||
              (state_q == COSW_WAIT && cfg.wait_periph_clock_stop_bit)) begin
            clock_out_pin_q <= clock_out_pin_q;
          end else begin
            clock_out_pin_q <= div32_level;
          end
        end
      endcase
    end
  end
  assign clock_out_pin = clock_out_pin_q;
  assign clock_out_pin_oe_n = !(single_chip_mode &&
                                cfg.clock_out_sel != COSEL_PORT);

  // expansion-mode bus pins
  logic low_power;
  assign low_power = (state_q != COSW_RUN);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_hold_q <= 8'h00;
    end else if (!low_power) begin
      bus_hold_q <= bus_pins_live;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_q <= 4'hf;
      ale_q <= 1'b1;
    end else if (low_power && !single_chip_mode) begin
      strobe_q <= 4'hf;
      ale_q <= 1'b1;
    end else begin
      strobe_q <= strobes_live;
      ale_q <= ale_live;
    end
  end

  assign bus_pins = bus_hold_q;
  assign strobes = strobe_q;
  assign ale = ale_q;
  assign hold_acknowledge = low_power ? 1'b1 : 1'b0;
  assign cpu_clock_pin = low_power ? 1'b1 : main_tick;
  assign mode = state_q;
endmodule : cosw_ctrl

// *** logic/cosw_divider.sv ***
// run-gated divider giving a one-cycle cpu enable and divided levels
module cosw_divider (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [4:0] cpu_ratio,
  // outputs
  output logic cpu_tick,
  output logic div8_level,
  output logic div32_level
);
  import cosw_pkg::*;
  logic [4:0] cnt_q;
  logic [4:0] cpu_cnt_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= CNT_ZERO;
    end else if (run) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_cnt_q <= CNT_ZERO;
    end else if (run) begin
      cpu_cnt_q <= (cpu_cnt_q >= cpu_ratio) ? CNT_ZERO : cpu_cnt_q + 5'h01;
    end
  end

  assign cpu_tick = run && (cpu_cnt_q >= cpu_ratio);
  assign div8_level = cnt_q[2];
  assign div32_level = cnt_q[4];
endmodule : cosw_divider

// *** logic/cosw_pkg.sv ***
// package: constants and carriers for the clock-out / stop / wait controller
package cosw_pkg;
  localparam logic [1:0] COSEL_PORT = 2'h0;
  localparam logic [1:0] COSEL_SUB = 2'h1;
  localparam logic [1:0] COSEL_DIV8 = 2'h2;
  localparam logic [1:0] COSEL_DIV32 = 2'h3;
  localparam logic [1:0] DIVSEL_NONE = 2'h0;
  localparam logic [1:0] DIVSEL_2 = 2'h1;
  localparam logic [1:0] DIVSEL_4 = 2'h2;
  localparam logic [1:0] DIVSEL_16 = 2'h3;
  localparam int DIV_W = 5;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam logic [4:0] RATIO_1 = 5'h00;
  localparam logic [4:0] RATIO_2 = 5'h01;
  localparam logic [4:0] RATIO_4 = 5'h03;
  localparam logic [4:0] RATIO_8 = 5'h07;
  localparam logic [4:0] RATIO_16 = 5'h0f;
  localparam logic DIVSEL0_RESET = 1'b1;
  localparam logic [1:0] COSEL_RESET = 2'h0;
  localparam logic [1:0] DIVSEL1_RESET = 2'h0;
  localparam logic [1:0] RESTART_CYCLES = 2'h2;
  localparam logic [1:0] RESTART_ZERO = 2'h0;
  localparam logic [4:0] CNT_ZERO = 5'h00;

  typedef enum logic [3:0] {
    COSW_RUN = 4'h1,
    COSW_WAIT = 4'h2,
    COSW_STOP = 4'h4,
    COSW_RESTART = 4'h8
  } cosw_state_e;

  typedef struct packed {
    logic [1:0] clock_out_sel;
    logic wait_periph_clock_stop_bit;
    logic divide_select1_low;
    logic divide_select1_high;
    logic system_clock_sub;
    logic main_clock_stopped;
  } cosw_cfg_s;

  typedef struct packed {
    logic cpu_clock_en;
    logic periph_clock_en;
    logic sub_clock_div32_en;
    logic sub_clock_en;
    logic converter_clock_en;
    logic watchdog_clock_en;
    logic ext_event_en;
    logic oscillator_en;
  } cosw_gate_s;
endpackage : cosw_pkg

// *** logic/cosw_sync.sv ***
// two-flop synchroniser for a pin level
module cosw_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // level
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : cosw_sync

// *** verification/cosw_cpu_model.sv ***
// cpu core and interrupt controller model that sleeps and wakes the block
module cosw_cpu_model (
  // clock and status
  input wire logic clk,
  input wire logic wake_ack,
  // requests and wake pins
  output logic all_clock_stop_bit_wr,
  output logic wait_instr,
  output logic wake_irq_pin,
  output logic wake_nmi_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    all_clock_stop_bit_wr = 1'b0;
    wait_instr = 1'b0;
    wake_irq_pin = 1'b0;
    wake_nmi_pin = 1'b0;
  end
  task automatic sleep(input logic stop);
    @(posedge clk);
    all_clock_stop_bit_wr <= stop;
    wait_instr <= !stop;
    @(posedge clk);
    all_clock_stop_bit_wr <= 1'b0;
    wait_instr <= 1'b0;
  endtask : sleep
  // only the chosen wake source is raised, all others stay at zero
  task automatic wake(input logic use_nmi, output logic ok);
    ok = 1'b0;
    @(posedge clk);
    wake_irq_pin <= !use_nmi;
    wake_nmi_pin <= use_nmi;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(negedge clk);
      ok = (wake_ack === 1'b1);
    end
    @(posedge clk);
    wake_irq_pin <= 1'b0;
    wake_nmi_pin <= 1'b0;
  endtask : wake
endmodule : cosw_cpu_model

// *** verification/cosw_ctrl_chk.sv ***
// assertions on the ports of the clock-out / stop / wait controller
module cosw_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // inputs
  input wire cosw_pkg::cosw_cfg_s cfg,
  input wire logic single_chip_mode,
  input wire logic all_clock_stop_bit_wr,
  input wire logic wait_instr,
  // outputs
  input wire logic divide_select_bit0,
  input wire cosw_pkg::cosw_state_e mode,
  input wire logic wake_ack,
  input wire logic run_isr,
  input wire cosw_pkg::cosw_gate_s gates,
  input wire logic clock_out_pin,
  input wire logic [7:0] bus_pins,
  input wire logic [3:0] strobes,
  input wire logic ale,
  input wire logic hold_acknowledge,
  input wire logic cpu_clock_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import cosw_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_stop_entry:
    assert property (mode == COSW_RUN && all_clock_stop_bit_wr
      |=> mode == COSW_STOP) else $error("stop not entered");
  a_wait_entry:
    assert property (mode == COSW_RUN && wait_instr && !all_clock_stop_bit_wr
      |=> mode == COSW_WAIT) else $error("wait not entered");
  a_stop_gates:
    assert property (mode == COSW_STOP |-> gates == 8'h02)
      else $error("wrong clock gates in stop");
  a_wait_gates:
    assert property (mode == COSW_WAIT |-> gates == {1'b0,
      !cfg.wait_periph_clock_stop_bit, 2'h3,
      !cfg.wait_periph_clock_stop_bit, 1'b0, 2'h3})
      else $error("wrong clock gates in wait");
  a_restart_path:
    assert property ($past(mode) == COSW_STOP && mode != COSW_STOP
      |-> mode == COSW_RESTART ##[1:3] mode == COSW_RUN)
      else $error("stop left without restart");
  a_wake_ack:
    assert property (mode == COSW_RUN && $past(mode) != COSW_RUN
      |-> wake_ack && run_isr) else $error("no wake pulse");
  a_pins_hold:
    assert property (!single_chip_mode && $past(mode) == mode &&
      (mode == COSW_STOP || mode == COSW_WAIT) |-> $stable(bus_pins) &&
      strobes == 4'hf && ale && hold_acknowledge && cpu_clock_pin)
      else $error("bus pins not held");
  a_stop_clock_out_pin:
    assert property (single_chip_mode && mode == COSW_STOP &&
      $past(mode) == COSW_STOP |-> (cfg.clock_out_sel == COSEL_SUB ?
      clock_out_pin : $stable(clock_out_pin)))
      else $error("clock out wrong in stop");
  a_wait_clock_out_pin:
    assert property (single_chip_mode && mode == COSW_WAIT &&
      $past(mode) == COSW_WAIT && cfg.wait_periph_clock_stop_bit &&
      cfg.clock_out_sel[1] |-> $stable(clock_out_pin))
      else $error("divided clock out runs in wait");
  a_div_stop:
    assert property (mode == COSW_RUN && all_clock_stop_bit_wr
      |=> divide_select_bit0 == ($past(cfg.system_clock_sub) ?
      $past(divide_select_bit0) : 1'b1)) else $error("divide bit wrong");
endmodule : cosw_chk

bind cosw_ctrl cosw_chk chk_u (.*);

// *** verification/cosw_ctrl_test.sv ***
// self-checking bench for the clock-out / stop / wait controller
module cosw_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cosw_pkg::*;
  logic clk, resetn, single_chip_mode, sub_clock, ale_live, ale, stop, ok;
  logic divide_select_bit0_wr, divide_select_bit0_wdata, divide_select_bit0;
  logic all_clock_stop_bit_wr, wait_instr, wake_irq_pin, wake_nmi_pin;
  logic wake_ack, run_isr, cpu_tick, clock_out_pin, clock_out_pin_oe_n;
  logic hold_acknowledge, cpu_clock_pin;
  logic [7:0] bus_pins_live, bus_pins, held, g;
  logic [3:0] strobes_live, strobes;
  logic [31:0] r;
  cosw_cfg_s cfg, c;
  cosw_state_e mode, want;
  cosw_gate_s gates;
  int failures, checks_done, seed;
  cosw_ctrl dut_u (.*);
  cosw_cpu_model cpu_u (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // sub clock at an eighth of the main rate, unrelated phase
  initial begin
    sub_clock = 1'b0;
    #7;
    forever #160 sub_clock = ~sub_clock;
  end
  function automatic logic [7:0] exp_ratio(logic b0, logic [1:0] d, logic s);
    if (s) return 8'h01;
    if (b0) return 8'h08;
    return 8'h01 << (d == 2'h3 ? 3'h4 : {1'b0, d});
  endfunction : exp_ratio
  function automatic logic [7:0] exp_tog(logic [1:0] s, cosw_state_e m,
                                         logic p);
    if (s == COSEL_PORT || m == COSW_STOP) return 8'h00;
    if (s == COSEL_SUB) return 8'h10;
    if (m == COSW_WAIT && p) return 8'h00;
    return s == COSEL_DIV8 ? 8'h10 : 8'h04;
  endfunction : exp_tog
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wrap_up();
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic tick_gap(output logic [7:0] gap);
    int i;
    for (i = 0; i < 40 && cpu_tick !== 1'b1; i++) @(negedge clk);
    gap = 8'h00;
    do begin
      @(negedge clk);
      gap++;
    end while (cpu_tick !== 1'b1 && gap < 8'h28);
  endtask : tick_gap
  task automatic toggles(output logic [7:0] t);
    logic last;
    t = 8'h00;
    @(negedge clk);
    last = clock_out_pin;
    repeat (64) begin
      @(negedge clk);
      if (clock_out_pin !== last) t++;
      last = clock_out_pin;
    end
  endtask : toggles
  task automatic wdiv(input logic v);
    @(posedge clk);
    divide_select_bit0_wr <= 1'b1;
    divide_select_bit0_wdata <= v;
    @(posedge clk);
    divide_select_bit0_wr <= 1'b0;
  endtask : wdiv
  initial begin
    resetn = 1'b0;
    seed = 64;
    failures = 0;
    checks_done = 0;
    cfg = '0;
    single_chip_mode = 1'b1;
    divide_select_bit0_wr = 1'b0;
    divide_select_bit0_wdata = 1'b0;
    bus_pins_live = 8'h00;
    strobes_live = 4'h0;
    ale_live = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    cmp(divide_select_bit0, 1'b1);
    tick_gap(g);
    tick_gap(g);
    cmp(g, 8'h08);
    for (int d = 0; d < 5; d++) begin
      @(posedge clk);
      {cfg.divide_select1_high, cfg.divide_select1_low} <= d[1:0];
      wdiv(d == 4);
      tick_gap(g);
      tick_gap(g);
      cmp(g, exp_ratio(d == 4, d[1:0], 1'b0));
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      c = r[6:0];
      c.main_clock_stopped = 1'b0;
      c.wait_periph_clock_stop_bit &= !c.system_clock_sub;
      stop = r[21];
      @(posedge clk);
      cfg <= c;
      single_chip_mode <= i[0];
      bus_pins_live <= r[15:8];
      strobes_live <= r[19:16];
      ale_live <= r[20];
      wdiv(1'b0);
      cmp(clock_out_pin_oe_n,
        !(i[0] && c.clock_out_sel != COSEL_PORT));
      if (i[0]) toggles(g);
      if (i[0]) cmp(g, exp_tog(c.clock_out_sel, COSW_RUN, 1'b0));
      cpu_u.sleep(stop);
      repeat (3) @(negedge clk);
      want = COSW_WAIT;
      if (stop) want = COSW_STOP;
      cmp(mode, want);
      held = bus_pins;
      @(posedge clk);
      bus_pins_live <= r[31:24] ^ 8'hff;
      strobes_live <= 4'h0;
      ale_live <= 1'b0;
      toggles(g);
      if (i[0]) cmp(g, exp_tog(c.clock_out_sel, want,
        c.wait_periph_clock_stop_bit));
      else cmp(held, bus_pins);
      if (!i[0]) cmp({4'h0, strobes}, 8'h0f);
      cpu_u.wake(r[22], ok);
      if (!ok) begin
        failures++;
        break;
      end
      cmp(divide_select_bit0, stop & !c.system_clock_sub);
      tick_gap(g);
      tick_gap(g);
      cmp(g, exp_ratio(stop & !c.system_clock_sub,
        {c.divide_select1_high, c.divide_select1_low}, c.system_clock_sub));
    end
    wdiv(1'b0);
    cpu_u.sleep(1'b0);
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    cmp({mode, 3'h0, divide_select_bit0}, {COSW_RUN, 4'h1});
    wrap_up();
  end
endmodule : cosw_ctrl_test
